/* File: inc/asrc_pkg.sv */
// Shared constants and types for the stereo asynchronous rate converter.
// Assumes one system clock; sample strobes arrive synchronous to it.
package asrc_pkg;

  // ----------------------------------------------------------------------
  // Data path widths and memory geometry
  // ----------------------------------------------------------------------
  localparam int DATA_W = 24;
  localparam int ADDR_W = 9;
  localparam int RAM_DEPTH = 512;
  localparam int PHASE_W = 20;
  localparam int TAP_W = 6;
  localparam int ROM_W = TAP_W + PHASE_W;
  localparam int POS_W = ADDR_W + PHASE_W;
  localparam int COEF_W = 18;
  localparam int ACC_W = 48;
  localparam int OUT_SHIFT = 16;
  localparam int STEP_W = 21;
  localparam int CNT_W = 14;

  // ----------------------------------------------------------------------
  // Coefficient store: a sparse set of entries, four per tap
  // ----------------------------------------------------------------------
  localparam int ROM_IDX_LSB = 18;
  localparam int ROM_FRAC_LSB = 10;
  localparam int ROM_FRAC_W = 8;
  localparam int ROM_LAST = 256;
  localparam int ROM_CENTER = 128;
  localparam int ROM_PEAK = 16384;
  localparam int ROM_SCALE_SHIFT = 2;
  localparam int QUAD_SHIFT = 17;

  // ----------------------------------------------------------------------
  // Write offset, group delay and mute fields
  // ----------------------------------------------------------------------
  localparam int MIN_OFFSET = 16;
  localparam int GD_DELAY_MSB = 6;
  localparam int GD_MUTE_BIT = 7;
  localparam int MUTE_GAIN_W = 9;
  localparam logic [MUTE_GAIN_W-1:0] MUTE_FULL = 9'h100;
  localparam int GAIN_SHIFT = 8;

  // ----------------------------------------------------------------------
  // Rate ratio unit
  // ----------------------------------------------------------------------
  localparam int RATIO_CNT_W = 10;
  localparam logic [5:0] RATIO_WIN_LAST = 6'h3F;
  localparam logic [RATIO_CNT_W-1:0] RATIO_WIN = 10'h040;
  localparam logic [RATIO_CNT_W-1:0] RATIO_HYST = 10'h002;
  localparam int RATIO_NUM_W = 27;
  localparam logic [RATIO_NUM_W-1:0] RATIO_NUM = 27'h4000000;
  localparam logic [STEP_W-1:0] UNITY_STEP = 21'h100000;

  // ----------------------------------------------------------------------
  // Servo loop gains and settling
  // ----------------------------------------------------------------------
  localparam int FAST_G1 = 1;
  localparam int FAST_G2 = 3;
  localparam int SLOW_G1 = 3;
  localparam int SLOW_G2 = 7;
  localparam logic [POS_W-1:0] FAST_THRESH = 29'h0010000;
  localparam logic [4:0] SETTLE_LAST = 5'h0F;
  localparam int FRAC_NUM_W = CNT_W + PHASE_W;
  localparam logic [PHASE_W-1:0] FRAC_MAX = 20'hFFFFF;

  typedef struct packed {
    logic signed [DATA_W-1:0] left;
    logic signed [DATA_W-1:0] right;
  } asrc_stereo_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_MEAS  = 6'h02,
    ST_LOAD  = 6'h04,
    ST_TAP_L = 6'h08,
    ST_TAP_R = 6'h10,
    ST_DONE  = 6'h20
  } asrc_state_t;

endpackage : asrc_pkg

/* File: logic/asrc_div.sv */
// Restoring unsigned divider, one quotient bit per enabled clock.
// Assumes the caller keeps num/den below 2^Q_W and waits for done.
`timescale 1ns/1ps
module asrc_div #(
  parameter int NUM_W = 27,
  parameter int DEN_W = 10,
  parameter int Q_W = 21
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [NUM_W-1:0] num,
  input wire logic [DEN_W-1:0] den,
  output logic done,
  output logic [Q_W-1:0] quot
);

  logic [NUM_W-1:0] num_sh;
  logic [DEN_W-1:0] den_r;
  logic [DEN_W:0] rem;
  logic [7:0] bits_left;
  logic busy;
  logic [DEN_W:0] next_rem;
  logic fits;

  // ----------------------------------------------------------------------
  // Trial subtraction
  // ----------------------------------------------------------------------
  assign next_rem = {rem[DEN_W-1:0], num_sh[NUM_W-1]};
  assign fits = (next_rem >= {1'b0, den_r});

  // Iteration; a start while busy is dropped
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      num_sh <= '0;
      den_r <= '0;
      rem <= '0;
      quot <= '0;
      bits_left <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start && !busy) begin
        num_sh <= num;
        den_r <= den;
        rem <= '0;
        quot <= '0;
        bits_left <= 8'(NUM_W);
        busy <= 1'b1;
      end else if (busy) begin
        rem <= fits ? (next_rem - {1'b0, den_r}) : next_rem;
        num_sh <= {num_sh[NUM_W-2:0], 1'b0};
        quot <= {quot[Q_W-2:0], fits};
        bits_left <= bits_left - 8'h01;
        if (bits_left == 8'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule : asrc_div

/* File: logic/asrc_top.sv */
// Stereo asynchronous sample rate converter: FIFO RAM, servo, ratio, FIR.
// Assumes in_valid and out_tick are one-cycle strobes on clk_sys.
//
// Operation
// - Output instant resolved to 2^20 sub-phases.
// - One convolution per output sample period.
// - 64 taps when output rate not lower.
// - Output arrival averaged from coarse measurements.
// - Sparse coefficient store, interpolated between entries.
// - Downsampling scales start, data, and length.
// - Input counter gives write address, servo ramp.
// - Servo tracks rates, gives start addresses.
// - Ratio unit drives coefficients, length, scaling.
// - Samples scaled for mute and ratio.
// - Downsampling multiplies input by out/in ratio.
// - 512 words per channel RAM.
// - Write offset keeps reader off writer.
// - Offset is 16 plus 7-bit delay.
// - Bit seven soft-mutes through FIFO scaling.
// - RAM address decrements; coefficient rollover ends.
// - Ratio one when upsampling; hysteresis two.
`timescale 1ns/1ps
module asrc_top import asrc_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire asrc_stereo_t in_sample,
  input wire logic out_tick,
  input wire logic [7:0] group_delay_mute,
  output logic out_valid,
  output asrc_stereo_t out_sample,
  output logic servo_fast,
  output logic [STEP_W-1:0] ratio_step
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic signed [DATA_W-1:0] ram_l [RAM_DEPTH], ram_r [RAM_DEPTH];
  logic [ADDR_W-1:0] wr_cnt, wr_addr, wr_snap;
  logic [CNT_W-1:0] since_in, tin;
  logic [MUTE_GAIN_W-1:0] mute_gain;
  logic [5:0] win_cnt;
  logic [RATIO_CNT_W-1:0] n_in, n_prev, n_diff;
  logic ratio_start, ratio_done;
  logic [STEP_W-1:0] ratio_quot;
  logic frac_start, frac_done;
  logic [STEP_W-1:0] frac_quot;
  logic [PHASE_W-1:0] frac;
  logic [POS_W-1:0] pred, inc;
  logic primed;
  logic [4:0] settle_cnt;
  logic [POS_W-1:0] meas, next_pred;
  logic signed [POS_W-1:0] err;
  logic [POS_W-1:0] err_abs;
  asrc_state_t state;
  logic [ADDR_W-1:0] rd_addr;
  logic [ROM_W-1:0] coef_addr;
  logic [STEP_W-1:0] conv_step;
  logic [ROM_W:0] next_coef_addr;
  logic signed [COEF_W-1:0] coef;
  logic signed [DATA_W-1:0] mac_in;
  logic signed [DATA_W+COEF_W-1:0] mac_prod;
  logic signed [ACC_W-1:0] acc_l, acc_r;
  logic [PHASE_W+STEP_W-1:0] start_prod;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Stored entry: smooth symmetric low-pass window, zero at both ends
  function automatic int rom_entry(input int idx);
    int x;
    x = idx - ROM_CENTER;
    if (idx > ROM_LAST) begin
      return 0;
    end
    return (ROM_PEAK - x * x) >>> ROM_SCALE_SHIFT;
  endfunction : rom_entry

  // Input scaling by ratio (Q20) and mute gain (Q8)
  function automatic logic signed [DATA_W-1:0] scale_in(input logic signed [DATA_W-1:0] s);
    logic signed [DATA_W+STEP_W+MUTE_GAIN_W+1:0] p;
    p = s * $signed({1'b0, ratio_step}) * $signed({1'b0, mute_gain});
    return DATA_W'(p >>> (PHASE_W + GAIN_SHIFT));
  endfunction : scale_in

  // Truncating the accumulator with clipping to full scale
  function automatic logic signed [DATA_W-1:0] sat_out(input logic signed [ACC_W-1:0] a);
    logic signed [ACC_W-1:0] s;
    s = a >>> OUT_SHIFT;
    if (s > $signed({{(ACC_W-DATA_W+1){1'b0}}, {(DATA_W-1){1'b1}}})) begin
      return {1'b0, {(DATA_W-1){1'b1}}};
    end else if (s < $signed({{(ACC_W-DATA_W+1){1'b1}}, {(DATA_W-1){1'b0}}})) begin
      return {1'b1, {(DATA_W-1){1'b0}}};
    end
    return DATA_W'(s);
  endfunction : sat_out

  // ----------------------------------------------------------------------
  // Input side: counter, period measure, soft mute, FIFO write
  // ----------------------------------------------------------------------
  // Writer stays ahead of the ramp by the offset, so the reader never laps it
  assign wr_addr = wr_cnt + ADDR_W'(MIN_OFFSET)
    + {2'b00, group_delay_mute[GD_DELAY_MSB:0]};

  // Input counter and coarse input period in system clocks
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_cnt <= '0;
      since_in <= '0;
      tin <= '0;
    end else if (clk_en) begin
      if (in_valid) begin
        wr_cnt <= wr_cnt + 9'h001;
        tin <= since_in + 14'h0001;
        since_in <= '0;
      end else if (since_in != {CNT_W{1'b1}}) begin
        since_in <= since_in + 14'h0001;
      end
    end
  end

  // Gain ramps one step per input sample to avoid clicks
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mute_gain <= '0;
    end else if (clk_en && in_valid) begin
      if (group_delay_mute[GD_MUTE_BIT]) begin
        if (mute_gain != '0) begin
          mute_gain <= mute_gain - 9'h001;
        end
      end else if (mute_gain != MUTE_FULL) begin
        mute_gain <= mute_gain + 9'h001;
      end
    end
  end

  // FIFO RAM, 512 words per channel, written pre-scaled
  always_ff @(posedge clk_sys) begin
    if (clk_en && in_valid) begin
      ram_l[wr_addr] <= scale_in(in_sample.left);
      ram_r[wr_addr] <= scale_in(in_sample.right);
    end
  end

  // ----------------------------------------------------------------------
  // Rate ratio unit
  // ----------------------------------------------------------------------
  assign n_diff = (n_in > n_prev) ? (n_in - n_prev) : (n_prev - n_in);

  // Inputs counted over a 64-output window; hysteresis stops length hunting
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      win_cnt <= '0;
      n_in <= '0;
      n_prev <= RATIO_WIN;
      ratio_start <= 1'b0;
      ratio_step <= UNITY_STEP;
    end else if (clk_en) begin
      ratio_start <= 1'b0;
      if (out_tick) begin
        win_cnt <= win_cnt + 6'h01;
      end
      if (out_tick && win_cnt == RATIO_WIN_LAST) begin
        n_in <= {{(RATIO_CNT_W-1){1'b0}}, in_valid};
        if (n_in <= RATIO_WIN) begin
          ratio_step <= UNITY_STEP;
          n_prev <= n_in;
        end else if (n_diff > RATIO_HYST) begin
          ratio_start <= 1'b1;
          n_prev <= n_in;
        end
      end else if (in_valid && n_in != {RATIO_CNT_W{1'b1}}) begin
        n_in <= n_in + 10'h001;
      end
      if (ratio_done) begin
        ratio_step <= (ratio_quot > UNITY_STEP) ? UNITY_STEP : ratio_quot;
      end
    end
  end

  // Step = 2^20 * out/in, also the input data scale
  asrc_div #(.NUM_W(RATIO_NUM_W), .DEN_W(RATIO_CNT_W), .Q_W(STEP_W)) u_ratio_div (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .start(ratio_start),
    .num(RATIO_NUM),
    .den(n_prev),
    .done(ratio_done),
    .quot(ratio_quot)
  );

  // ----------------------------------------------------------------------
  // Digital servo loop
  // ----------------------------------------------------------------------
  // Coarse phase of the output tick inside the current input period
  asrc_div #(.NUM_W(FRAC_NUM_W), .DEN_W(CNT_W), .Q_W(STEP_W)) u_frac_div (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .start(frac_start),
    .num({since_in, {PHASE_W{1'b0}}}),
    .den(tin),
    .done(frac_done),
    .quot(frac_quot)
  );

  // A stalled input can push the measure past one period: clip it
  assign frac = (frac_quot > {1'b0, FRAC_MAX}) ? FRAC_MAX : frac_quot[PHASE_W-1:0];
  assign meas = {wr_snap - 9'h001, frac};
  assign next_pred = pred + inc;
  assign err = $signed(meas - next_pred);
  assign err_abs = err[POS_W-1] ? POS_W'(-err) : POS_W'(err);

  // Second-order loop; the first measure loads the ramp, each later one only nudges it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pred <= '0;
      inc <= POS_W'(UNITY_STEP);
      primed <= 1'b0;
      servo_fast <= 1'b1;
      settle_cnt <= '0;
    end else if (clk_en && frac_done) begin
      primed <= 1'b1;
      if (!primed) begin
        pred <= meas;
      end else if (servo_fast) begin
        pred <= next_pred + POS_W'(err >>> FAST_G1);
        inc <= inc + POS_W'(err >>> FAST_G2);
      end else begin
        pred <= next_pred + POS_W'(err >>> SLOW_G1);
        inc <= inc + POS_W'(err >>> SLOW_G2);
      end
      // Large error means start-up or a rate change
      if (err_abs > FAST_THRESH) begin
        servo_fast <= 1'b1;
        settle_cnt <= '0;
      end else if (servo_fast) begin
        settle_cnt <= settle_cnt + 5'h01;
        if (settle_cnt == SETTLE_LAST) begin
          servo_fast <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Coefficient interpolation
  // ----------------------------------------------------------------------
  // Quadratic fit over three stored entries around the exact phase
  always_comb begin
    int idx, fi, p0, p1, p2, c;
    idx = int'(coef_addr[ROM_W-1:ROM_IDX_LSB]);
    fi = int'(coef_addr[ROM_IDX_LSB-1:ROM_FRAC_LSB]);
    p0 = rom_entry(idx);
    p1 = rom_entry(idx + 1);
    p2 = rom_entry(idx + 2);
    c = p0 + (((p1 - p0) * fi) >>> ROM_FRAC_W)
      + (((p2 - 2 * p1 + p0) * fi * (fi - (1 << ROM_FRAC_W))) >>> QUAD_SHIFT);
    coef = COEF_W'(c);
  end

  // ----------------------------------------------------------------------
  // Convolution engine: one MAC shared by both channels
  // ----------------------------------------------------------------------
  assign mac_in = (state == ST_TAP_L) ? ram_l[rd_addr] : ram_r[rd_addr];
  assign mac_prod = mac_in * coef;
  assign next_coef_addr = {1'b0, coef_addr} + (ROM_W + 1)'(conv_step);
  assign start_prod = pred[PHASE_W-1:0] * ratio_step; // Full width keeps the phase

  // Tick while busy is dropped; the servo never measures it, only win_cnt counts it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      frac_start <= 1'b0;
      wr_snap <= '0;
      rd_addr <= '0;
      coef_addr <= '0;
      conv_step <= UNITY_STEP;
      acc_l <= '0;
      acc_r <= '0;
      out_valid <= 1'b0;
      out_sample <= '0;
    end else if (clk_en) begin
      frac_start <= 1'b0;
      out_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (out_tick) begin
            frac_start <= 1'b1;
            state <= ST_MEAS;
          end
        end
        ST_MEAS: begin
          // Counter caught with the divider's numerator, so an input between can't skew it
          if (frac_start) begin
            wr_snap <= wr_cnt;
          end
          if (frac_done) begin
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Integer part picks the sample, fraction the phase
          rd_addr <= pred[POS_W-1:PHASE_W];
          coef_addr <= ROM_W'(start_prod[PHASE_W+STEP_W-1:PHASE_W]);
          conv_step <= ratio_step;
          acc_l <= '0;
          acc_r <= '0;
          state <= ST_TAP_L;
        end
        ST_TAP_L: begin
          acc_l <= acc_l + ACC_W'(mac_prod);
          state <= ST_TAP_R;
        end
        ST_TAP_R: begin
          acc_r <= acc_r + ACC_W'(mac_prod);
          // Smaller step stretches the taps: length grows by in/out
          coef_addr <= next_coef_addr[ROM_W-1:0];
          rd_addr <= rd_addr - 9'h001;
          state <= next_coef_addr[ROM_W] ? ST_DONE : ST_TAP_L;
        end
        ST_DONE: begin
          out_sample.left <= sat_out(acc_l);
          out_sample.right <= sat_out(acc_r);
          out_valid <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : asrc_top

/* File: verification/asrc_top_assertions.sv */
// Port-level checks for the stereo rate converter.
// Assumes one clk_sys domain and synchronous active-high reset.
`timescale 1ns/1ps
module asrc_top_assertions import asrc_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire asrc_stereo_t in_sample,
  input wire logic out_tick,
  input wire logic [7:0] group_delay_mute,
  input wire logic out_valid,
  input wire asrc_stereo_t out_sample,
  input wire logic servo_fast,
  input wire logic [STEP_W-1:0] ratio_step
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  int tick_age;
  int ticks_run;
  int ratio_ticks;

  // Age saturates high after reset, so an answer without a tick fails
  always_ff @(posedge clk_sys) begin
    if (reset)
      tick_age <= 2047;
    else if (clk_en && out_tick)
      tick_age <= 0;
    else if (clk_en && tick_age < 2047)
      tick_age <= tick_age + 1;
  end

  // Ticks since reset, for the settling floor
  always_ff @(posedge clk_sys) begin
    if (reset)
      ticks_run <= 0;
    else if (clk_en && out_tick && ticks_run < 255)
      ticks_run <= ticks_run + 1;
  end

  // Ticks since the ratio last moved
  always_ff @(posedge clk_sys) begin
    if (reset || $changed(ratio_step))
      ratio_ticks <= 0;
    else if (clk_en && out_tick && ratio_ticks < 255)
      ratio_ticks <= ratio_ticks + 1;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_valid_pulse: assert property (out_valid && clk_en |=> !out_valid)
    else $error("out_valid held past one cycle");
  a_sample_held: assert property ($changed(out_sample) |-> out_valid)
    else $error("out_sample moved without out_valid");
  a_tick_answer: assert property (out_tick && clk_en |-> ##[150:1000] out_valid)
    else $error("tick not answered in time");
  a_answer_age: assert property (out_valid |-> tick_age >= 150 && tick_age <= 1000)
    else $error("out_valid without a recent tick");
  a_ratio_range: assert property (ratio_step <= UNITY_STEP && ratio_step != '0)
    else $error("ratio_step outside its range");
  a_ratio_gap: assert property ($changed(ratio_step) |-> ratio_ticks >= 64)
    else $error("ratio_step moved inside a window");
  a_fast_hold: assert property ($fell(servo_fast) |-> ticks_run >= 16)
    else $error("servo left fast mode too soon");
  a_freeze_hold: assert property (!clk_en |=> $stable(out_sample) && $stable(ratio_step))
    else $error("state moved while clk_en low");
  a_reset_state: assert property (disable iff (1'b0)
    reset && clk_en |=> servo_fast && ratio_step == UNITY_STEP && !out_valid)
    else $error("reset state wrong");

  c_muted_out: cover property (out_valid && group_delay_mute[7]);
  c_settled: cover property ($fell(servo_fast));
  c_down_out: cover property (out_valid && ratio_step != UNITY_STEP);
  c_frozen_tick: cover property (!clk_en && out_tick);
endmodule : asrc_top_assertions

/* File: verification/asrc_stream_model.sv */
// Far-side model: input port strobes and the output sample clock.
// Assumes periods in clk_sys cycles, the output period set above the answer latency.
`timescale 1ns/1ps
module asrc_stream_model import asrc_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] in_period,
  input wire logic [15:0] out_period,
  input wire asrc_stereo_t level,
  output logic in_valid,
  output asrc_stereo_t in_sample,
  output logic out_tick,
  output int ticks
);
  logic [15:0] in_cnt;
  logic [15:0] out_cnt;

  // Input strobe; data shows the inverse between samples
  always @(negedge clk_sys) begin
    if (reset || in_period == '0) begin
      in_cnt <= '0;
      in_valid <= 1'b0;
      in_sample <= ~level;
    end else begin
      in_valid <= (in_cnt >= in_period - 16'h0001);
      in_sample <= (in_cnt >= in_period - 16'h0001) ? level : ~level;
      in_cnt <= (in_cnt >= in_period - 16'h0001) ? '0 : in_cnt + 16'h0001;
    end
  end

  // Output sample clock; a shorter period ends the current gap early, at once if already past it
  always @(negedge clk_sys) begin
    if (reset || out_period == '0) begin
      out_cnt <= '0;
      out_tick <= 1'b0;
    end else begin
      out_tick <= (out_cnt >= out_period - 16'h0001);
      out_cnt <= (out_cnt >= out_period - 16'h0001) ? '0 : out_cnt + 16'h0001;
    end
  end

  // Tick count, read by the bench off the falling edge
  always @(posedge clk_sys) begin
    if (reset)
      ticks <= 0;
    else if (out_tick)
      ticks <= ticks + 1;
  end
endmodule : asrc_stream_model

/* File: verification/tb_asrc_top.sv */
// Self-checking bench for the rate converter.
// Assumes the stream model as far side; inputs change on falling edges.
`timescale 1ns/1ps
module tb_asrc_top;
  import asrc_pkg::*;
  logic clk_sys;
  logic reset;
  logic clk_en;
  logic in_valid;
  logic out_tick;
  logic out_valid;
  logic servo_fast;
  asrc_stereo_t in_sample;
  asrc_stereo_t out_sample;
  asrc_stereo_t level;
  logic [7:0] group_delay_mute;
  logic [STEP_W-1:0] ratio_step;
  logic [15:0] in_period;
  logic [15:0] out_period;
  int ticks;
  int fails;
  int check_count;

  asrc_stream_model u_src (.clk_sys(clk_sys), .reset(reset), .in_period(in_period),
    .out_period(out_period), .level(level), .in_valid(in_valid),
    .in_sample(in_sample), .out_tick(out_tick), .ticks(ticks));

  asrc_top u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .in_valid(in_valid),
    .in_sample(in_sample), .out_tick(out_tick), .group_delay_mute(group_delay_mute),
    .out_valid(out_valid), .out_sample(out_sample), .servo_fast(servo_fast),
    .ratio_step(ratio_step));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // One tick and its answer; a second tick first means a lost result
  task automatic one_tick(output int lat);
    int t0;
    int n;
    t0 = ticks;
    n = 0;
    lat = 0;
    while (ticks == t0 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    while (out_valid !== 1'b1 && lat < 2000) begin
      @(negedge clk_sys);
      lat++;
    end
    if (n >= 2000 || lat >= 2000) begin
      fails++;
      results();
    end else begin
      check(32'(ticks - t0), 64'h1);
    end
  endtask : one_tick

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(out_valid, 64'h0);
    check(out_sample, 64'h0);
    check(servo_fast, 64'h1);
    check(ratio_step, UNITY_STEP);
  endtask : t_reset

  // Muted from reset: stored samples stay zero, servo settles
  task automatic t_muted();
    int lat;
    in_period <= 16'h00BE;
    out_period <= 16'h00AA;
    repeat (120) one_tick(lat);
    check(lat < 200, 64'h1);
    check(out_sample, 64'h0);
    check(servo_fast, 64'h0);
    check(ratio_step, UNITY_STEP);
  endtask : t_muted

  // Unmute ramps the level up; equal channels give equal results
  task automatic t_unmute();
    int lat;
    asrc_stereo_t first;
    group_delay_mute <= 8'h0A;
    repeat (45) one_tick(lat); // Newest read sample trails the writer by the offset
    first = out_sample;
    repeat (30) one_tick(lat);
    check(first.left > 0, 64'h1);
    check(out_sample.left > first.left, 64'h1);
    check(out_sample.left, out_sample.right);
  endtask : t_unmute

  // Faster input: ratio follows 64 ticks of input count, filter lengthens
  task automatic t_down();
    int lat;
    logic found;
    found = 1'b0;
    in_period <= 16'h00C8;
    out_period <= 16'h012C;
    repeat (140) one_tick(lat);
    for (int n = 94; n <= 98; n++) begin
      if (ratio_step === 21'(RATIO_NUM / n)) found = 1'b1;
    end
    check(found, 64'h1);
    check(lat > 200, 64'h1);
    check(out_sample.left > 0, 64'h1);
    check(out_sample.left, out_sample.right);
  endtask : t_down

  // Frozen engine produces nothing, ticks meanwhile are dropped
  task automatic t_freeze();
    int lat;
    asrc_stereo_t keep;
    repeat (2) @(negedge clk_sys);
    keep = out_sample;
    clk_en <= 1'b0;
    repeat (400) @(negedge clk_sys);
    check(out_sample, keep);
    check(out_valid, 64'h0);
    clk_en <= 1'b1;
    one_tick(lat);
  endtask : t_freeze

  // ----------------------------------------
  // Clock and main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    fails = 0;
    check_count = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    in_period = '0;
    out_period = '0;
    group_delay_mute = 8'h8A;
    level = {24'h100000, 24'h100000};
    repeat (2) @(negedge clk_sys);
    t_reset();
    reset <= 1'b0;
    t_muted();
    t_unmute();
    t_down();
    t_freeze();
    results();
  end
endmodule : tb_asrc_top

bind asrc_top asrc_top_assertions u_chk (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
  .in_valid(in_valid), .in_sample(in_sample), .out_tick(out_tick),
  .group_delay_mute(group_delay_mute), .out_valid(out_valid), .out_sample(out_sample),
  .servo_fast(servo_fast), .ratio_step(ratio_step));
